// ===== design/scsd_pkg.sv
// Types shared by the clock select and divide block
package scsd_pkg;
	typedef enum logic [2:0] {
		SRC_RC_FAST = 3'h0,
		SRC_RC_FAST_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_RC_SLOW = 3'h5,
		SRC_RC_DIV16 = 3'h6,
		SRC_RC_DIVN = 3'h7
	} scsd_src_e;
	typedef struct packed {
		logic [2:0] initial_source_config;
		logic [1:0] primary_submode_config;
		logic osc_pin_function_config;
		logic [1:0] switch_monitor_config;
	} scsd_cfg_s;
	typedef struct packed {
		logic [2:0] doze_ratio;
		logic [2:0] fast_rc_postscaler;
		logic [1:0] pll_output_divider;
		logic [4:0] pll_input_prescaler;
	} scsd_div_s;
	typedef enum {
		SW_IDLE,
		SW_WAIT_READY,
		SW_COUNT
	} scsd_sw_e;
endpackage : scsd_pkg

// ===== design/scsd_regs.svh
// Register offsets, field positions, reset values and timing counts for the clock selector
`ifndef SCSD_REGS_SVH
`define SCSD_REGS_SVH
`define SCSD_OFS_OSC_CTRL 12'h000
`define SCSD_OFS_CLK_DIV 12'h004
`define SCSD_OFS_STATUS 12'h008
`define SCSD_CUR_MSB 14
`define SCSD_CUR_LSB 12
`define SCSD_REQ_MSB 10
`define SCSD_REQ_LSB 8
`define SCSD_BIT_SRC_LOCK 7
`define SCSD_BIT_PIN_LOCK 6
`define SCSD_BIT_PLL_LOCK 5
`define SCSD_BIT_FAIL 3
`define SCSD_BIT_SEC_EN 1
`define SCSD_BIT_SWITCH 0
`define SCSD_BIT_RECOVER 15
`define SCSD_DOZE_MSB 14
`define SCSD_DOZE_LSB 12
`define SCSD_BIT_DOZE_EN 11
`define SCSD_PSC_MSB 10
`define SCSD_PSC_LSB 8
`define SCSD_POST_MSB 7
`define SCSD_POST_LSB 6
`define SCSD_PRE_MSB 4
`define SCSD_PRE_LSB 0
`define SCSD_RST_DOZE 3'h3
`define SCSD_RST_PSC 3'h0
`define SCSD_RST_POST 2'h1
`define SCSD_RST_PRE 5'h00
`define SCSD_POST_RESERVED 2'h2
`define SCSD_SWITCH_WAIT 4'hA
`define SCSD_CFG_SWITCH_ONLY 2'h1
`endif

// ===== design/scsd_top.sv
// Clock select and divide control: oscillator control and divisor registers on AHB-Lite
// Notes on behaviour
// [R1] Power-on clock mode taken from the 3-bit initial source configuration field.
// [R2] Primary submode from 2-bit config field; ignored for non-primary sources.
// [R3] Erased configuration (all ones) starts in fast RC divide-by-N mode.
// [R4] Current source readable at control bits 14-12, read only.
// [R5] Requested source writable at bits 10-8, loaded from configuration at reset.
// [R6] With switch-only config, source lock bit set blocks clock switching.
// [R7] Pin select lock set refuses writes to pin select registers.
// [R8] PLL lock flag reads one when locked or start-up timer done.
// [R9] Clock fail flag set on monitor failure; software clears it; resets zero.
// [R10] Secondary oscillator enable bit turns that oscillator on or off; the code keeps it on while it is the current source.
// [R11] Switch request bit stays set until switch done, then clears.
// [R12] Unimplemented control bits 15,11,4,2 and divisor bit 5 read zero.
// [R13] Recover-on-interrupt set makes any interrupt clear doze enable.
// [R14] Doze field divides processor clock by two to the field value.
// [R15] Doze enable off forces processor to peripheral ratio to one.
// [R16] Fast RC postscaler field selects divide 1,2,2,8,16,32,64,256.
// [R17] PLL output divider 00 by 2, 01 by 4, 11 by 8; 10 reserved.
// [R18] PLL input prescaler divides by field value plus two.
// [R19] Second oscillator pin function follows its config bit for non-primary modes.
// [R20] Instruction clock is oscillator output divided by two.
// [R21] Switch to the source already in use clears request without switching.
// [R22] After new source ready, wait ten new clocks, copy source, clear request.
// [R23] Doze and postscaler dividers change ratio only on a divided boundary.
// [R24] Divisor resets: doze 011, postscaler 000, output divider 01, prescaler 0.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "scsd_regs.svh"
module scsd_top (
	input wire logic hclk, // Bus clock, 10 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [11:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic hready, // Bus ready in
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	input wire scsd_pkg::scsd_cfg_s cfg, // Nonvolatile configuration bits
	input wire logic pll_locked_async, // PLL lock from analog
	input wire logic src_ready_async, // Requested oscillator started
	input wire logic new_clk_async, // Requested clock, sampled
	input wire logic clk_fail_async, // Fail-safe monitor failure
	input wire logic irq_async, // Any interrupt pending
	output scsd_pkg::scsd_src_e active_source, // Source in use
	output logic [1:0] primary_submode, // Primary submode to oscillator
	output logic osc2_is_gpio, // Second oscillator pin as plain I/O
	output logic sec_osc_on, // Secondary oscillator enable
	output logic pin_select_locked, // Pin select write refuse
	output scsd_pkg::scsd_div_s div_out, // Effective divider settings
	output logic cpu_clk_en, // Processor clock enable pulse
	output logic periph_clk_en, // Peripheral instruction clock enable
	output logic rc_div_en // Postscaled fast RC tick
);
	logic [2:0] cur_src_ff;
	logic [2:0] req_src_ff;
	logic src_lock_ff;
	logic pin_lock_ff;
	logic fail_ff;
	logic sec_en_ff;
	logic switch_ff;
	logic rec_irq_ff;
	logic doze_en_ff;
	scsd_pkg::scsd_div_s div_ff;
	logic init_done_ff;
	logic [4:0] s1_ff;
	logic [4:0] s2_ff;
	logic new_clk_d_ff;
	logic [3:0] sw_cnt_ff;
	scsd_pkg::scsd_sw_e sw_st_ff;
	logic wr_ph_ff;
	logic rd_ph_ff;
	logic [11:0] ph_addr_ff;
	logic [7:0] doze_cnt_ff;
	logic [2:0] doze_act_ff;
	logic [7:0] psc_cnt_ff;
	logic [2:0] psc_act_ff;
	logic fcy_ff;
	logic [31:0] osc_word;
	logic [31:0] div_word;
	logic pll_lock_s;
	logic src_ready_s;
	logic new_clk_s;
	logic fail_s;
	logic irq_s;
	logic new_edge;
	logic sw_allowed;
	logic wr_osc;
	logic wr_div;
	logic [1:0] nxt_post;

	// Postscaler code to terminal count
	function automatic logic [7:0] psc_limit(input logic [2:0] code);
		unique case (code)
			3'h0: psc_limit = 8'h00;
			3'h1, 3'h2: psc_limit = 8'h01; // [R16]
			3'h3: psc_limit = 8'h07;
			3'h4: psc_limit = 8'h0F;
			3'h5: psc_limit = 8'h1F;
			3'h6: psc_limit = 8'h3F;
			3'h7: psc_limit = 8'hFF;
		endcase
	endfunction : psc_limit

	// Power of two minus one for the doze ratio
	function automatic logic [7:0] doze_limit(input logic [2:0] code);
		doze_limit = 8'((9'h001 << code) - 9'h001); // [R14]
	endfunction : doze_limit

	// Two-flop synchronisers for outside inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff <= 5'h00;
			s2_ff <= 5'h00;
		end else begin
			s1_ff <= {irq_async, clk_fail_async, new_clk_async, src_ready_async, pll_locked_async};
			s2_ff <= s1_ff;
		end
	end
	assign pll_lock_s = s2_ff[0];
	assign src_ready_s = s2_ff[1];
	assign new_clk_s = s2_ff[2];
	assign fail_s = s2_ff[3];
	assign irq_s = s2_ff[4];

	// Rising edges of the sampled new clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			new_clk_d_ff <= 1'b0;
		end else begin
			new_clk_d_ff <= new_clk_s;
		end
	end
	assign new_edge = new_clk_s && !new_clk_d_ff;

	// AHB-Lite data phase capture, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_ff <= 1'b0;
			rd_ph_ff <= 1'b0;
			ph_addr_ff <= 12'h000;
		end else if (hready) begin
			wr_ph_ff <= hsel && htrans[1] && hwrite;
			rd_ph_ff <= hsel && htrans[1] && !hwrite;
			ph_addr_ff <= haddr;
		end
	end
	assign wr_osc = wr_ph_ff && (ph_addr_ff == `SCSD_OFS_OSC_CTRL);
	assign wr_div = wr_ph_ff && (ph_addr_ff == `SCSD_OFS_CLK_DIV);
	assign sw_allowed = (cfg.switch_monitor_config[1] == 1'b0) &&
		!((cfg.switch_monitor_config == `SCSD_CFG_SWITCH_ONLY) && src_lock_ff); // [R6]

	// Strap capture one cycle after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_done_ff <= 1'b0;
		end else begin
			init_done_ff <= 1'b1;
		end
	end

	// Current and requested source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_src_ff <= 3'h7; // [R3]
			req_src_ff <= 3'h7;
		end else if (!init_done_ff) begin
			cur_src_ff <= cfg.initial_source_config; // [R1]
			req_src_ff <= cfg.initial_source_config; // [R5]
		end else begin
			if (sw_st_ff == scsd_pkg::SW_COUNT && new_edge && sw_cnt_ff == `SCSD_SWITCH_WAIT - 4'h1)
				cur_src_ff <= req_src_ff; // [R22]
			if (wr_osc && sw_st_ff == scsd_pkg::SW_IDLE && !src_lock_ff)
				req_src_ff <= hwdata[`SCSD_REQ_MSB:`SCSD_REQ_LSB]; // [R5]
		end
	end

	// Switch sequencer and request bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_st_ff <= scsd_pkg::SW_IDLE;
			switch_ff <= 1'b0;
			sw_cnt_ff <= 4'h0;
		end else begin
			unique case (sw_st_ff)
				scsd_pkg::SW_IDLE: begin
					sw_cnt_ff <= 4'h0;
					if (wr_osc && hwdata[`SCSD_BIT_SWITCH] && sw_allowed && init_done_ff) begin
						if (hwdata[`SCSD_REQ_MSB:`SCSD_REQ_LSB] != cur_src_ff || src_lock_ff) begin
							switch_ff <= 1'b1; // [R11]
							sw_st_ff <= scsd_pkg::SW_WAIT_READY;
						end
					end
				end
				scsd_pkg::SW_WAIT_READY: begin
					if (req_src_ff == cur_src_ff) begin
						switch_ff <= 1'b0; // [R21]
						sw_st_ff <= scsd_pkg::SW_IDLE;
					end else if (src_ready_s) begin
						sw_st_ff <= scsd_pkg::SW_COUNT;
					end
				end
				scsd_pkg::SW_COUNT: begin
					if (new_edge) begin
						if (sw_cnt_ff == `SCSD_SWITCH_WAIT - 4'h1) begin
							switch_ff <= 1'b0; // [R22]
							sw_st_ff <= scsd_pkg::SW_IDLE;
						end else begin
							sw_cnt_ff <= sw_cnt_ff + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Lock, fail and enable flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_lock_ff <= 1'b0;
			pin_lock_ff <= 1'b0;
			sec_en_ff <= 1'b0;
			fail_ff <= 1'b0;
		end else begin
			if (wr_osc) begin
				src_lock_ff <= hwdata[`SCSD_BIT_SRC_LOCK];
				pin_lock_ff <= hwdata[`SCSD_BIT_PIN_LOCK]; // [R7]
				sec_en_ff <= hwdata[`SCSD_BIT_SEC_EN]; // [R10]
			end
			if (fail_s)
				fail_ff <= 1'b1; // [R9]
			else if (wr_osc && !hwdata[`SCSD_BIT_FAIL])
				fail_ff <= 1'b0;
		end
	end

	// Divisor register with post divider reserved code kept out
	assign nxt_post = (hwdata[`SCSD_POST_MSB:`SCSD_POST_LSB] == `SCSD_POST_RESERVED) ?
		div_ff.pll_output_divider : hwdata[`SCSD_POST_MSB:`SCSD_POST_LSB]; // [R17]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_irq_ff <= 1'b0;
			doze_en_ff <= 1'b0;
			div_ff <= '{`SCSD_RST_DOZE, `SCSD_RST_PSC, `SCSD_RST_POST, `SCSD_RST_PRE}; // [R24]
		end else begin
			if (wr_div) begin
				rec_irq_ff <= hwdata[`SCSD_BIT_RECOVER];
				div_ff.doze_ratio <= hwdata[`SCSD_DOZE_MSB:`SCSD_DOZE_LSB];
				div_ff.fast_rc_postscaler <= hwdata[`SCSD_PSC_MSB:`SCSD_PSC_LSB];
				div_ff.pll_output_divider <= nxt_post;
				div_ff.pll_input_prescaler <= hwdata[`SCSD_PRE_MSB:`SCSD_PRE_LSB]; // [R18]
			end
			if (irq_s && (wr_div ? hwdata[`SCSD_BIT_RECOVER] : rec_irq_ff))
				doze_en_ff <= 1'b0; // [R13]
			else if (wr_div)
				doze_en_ff <= hwdata[`SCSD_BIT_DOZE_EN];
		end
	end

	// Instruction clock as half the oscillator rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fcy_ff <= 1'b0;
		end else begin
			fcy_ff <= !fcy_ff; // [R20]
		end
	end

	// Doze divider, ratio taken only at wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			doze_cnt_ff <= 8'h00;
			doze_act_ff <= 3'h0;
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
		end else begin
			periph_clk_en <= fcy_ff;
			cpu_clk_en <= 1'b0;
			if (fcy_ff) begin
				if (!doze_en_ff) begin
					cpu_clk_en <= 1'b1; // [R15]
					doze_cnt_ff <= 8'h00;
				end else if (doze_cnt_ff >= doze_limit(doze_act_ff)) begin
					cpu_clk_en <= 1'b1;
					doze_cnt_ff <= 8'h00;
					doze_act_ff <= div_ff.doze_ratio; // [R23]
				end else begin
					doze_cnt_ff <= doze_cnt_ff + 8'h01;
				end
			end
		end
	end

	// Fast RC postscaler, ratio taken only at wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psc_cnt_ff <= 8'h00;
			psc_act_ff <= `SCSD_RST_PSC;
			rc_div_en <= 1'b0;
		end else if (psc_cnt_ff >= psc_limit(psc_act_ff)) begin
			psc_cnt_ff <= 8'h00;
			psc_act_ff <= div_ff.fast_rc_postscaler; // [R23]
			rc_div_en <= 1'b1;
		end else begin
			psc_cnt_ff <= psc_cnt_ff + 8'h01;
			rc_div_en <= 1'b0;
		end
	end

	// Registered outputs toward the oscillators
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_source <= scsd_pkg::SRC_RC_DIVN;
			primary_submode <= 2'h0;
			osc2_is_gpio <= 1'b0;
			sec_osc_on <= 1'b0;
			pin_select_locked <= 1'b0;
			div_out <= '0;
		end else begin
			active_source <= scsd_pkg::scsd_src_e'(cur_src_ff); // [R4]
			primary_submode <= (cur_src_ff == 3'h2 || cur_src_ff == 3'h3) ?
				cfg.primary_submode_config : 2'h0; // [R2]
			osc2_is_gpio <= (cur_src_ff != 3'h2 && cur_src_ff != 3'h3) ||
				(cfg.primary_submode_config == 2'h0) ?
				cfg.osc_pin_function_config : 1'b0; // [R19]
			sec_osc_on <= sec_en_ff || (cur_src_ff == 3'h4);
			pin_select_locked <= pin_lock_ff; // [R7]
			div_out <= div_ff;
		end
	end

	// Read words, unimplemented bits zero
	assign osc_word = {16'h0000, 1'b0, cur_src_ff, 1'b0, req_src_ff, src_lock_ff, pin_lock_ff,
		pll_lock_s, 1'b0, fail_ff, 1'b0, sec_en_ff, switch_ff}; // [R12] [R8]
	assign div_word = {16'h0000, rec_irq_ff, div_ff.doze_ratio, doze_en_ff,
		div_ff.fast_rc_postscaler, div_ff.pll_output_divider, 1'b0,
		div_ff.pll_input_prescaler}; // [R12]

	// Read data register and response
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				unique case (haddr)
					`SCSD_OFS_OSC_CTRL: hrdata <= osc_word;
					`SCSD_OFS_CLK_DIV: hrdata <= div_word;
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Checks
	a_switch_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		(sw_st_ff == scsd_pkg::SW_COUNT && new_edge && sw_cnt_ff == 4'h9) |=> !switch_ff) // [R22]
		else $error("switch request not cleared after wait");
	a_cur_copies: assert property (@(posedge hclk) disable iff (!hresetn)
		(sw_st_ff == scsd_pkg::SW_COUNT && new_edge && sw_cnt_ff == 4'h9)
		|=> cur_src_ff == $past(req_src_ff)) // [R22]
		else $error("current source not copied");
	a_redundant_abort: assert property (@(posedge hclk) disable iff (!hresetn)
		(sw_st_ff == scsd_pkg::SW_WAIT_READY && req_src_ff == cur_src_ff)
		|=> sw_st_ff == scsd_pkg::SW_IDLE && !switch_ff) // [R21]
		else $error("redundant switch not aborted");
	a_fail_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		fail_s |=> fail_ff) // [R9]
		else $error("fail flag missed");
	a_recover_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq_s && rec_irq_ff && !wr_div) |=> !doze_en_ff) // [R13]
		else $error("doze enable not cleared by interrupt");
	a_doze_off_full: assert property (@(posedge hclk) disable iff (!hresetn)
		(!doze_en_ff && fcy_ff) |=> cpu_clk_en) // [R15]
		else $error("processor clock slowed without doze");
	a_post_no_resv: assert property (@(posedge hclk) disable iff (!hresetn)
		div_ff.pll_output_divider != 2'h2) // [R17]
		else $error("reserved output divider stored");
	a_zero_bits: assert property (@(posedge hclk) disable iff (!hresetn)
		osc_word[15] == 1'b0 && osc_word[11] == 1'b0 && osc_word[4] == 1'b0 &&
		osc_word[2] == 1'b0 && div_word[5] == 1'b0) // [R12]
		else $error("unimplemented bit reads one");
	a_fcy_toggles: assert property (@(posedge hclk) disable iff (!hresetn)
		fcy_ff |=> !fcy_ff ##1 fcy_ff) // [R20]
		else $error("instruction clock not half rate");
	c_switch_done: cover property (@(posedge hclk) disable iff (!hresetn)
		$fell(switch_ff) && sw_st_ff == scsd_pkg::SW_IDLE);
	c_redundant: cover property (@(posedge hclk) disable iff (!hresetn)
		sw_st_ff == scsd_pkg::SW_WAIT_READY && req_src_ff == cur_src_ff);
	c_doze_slow: cover property (@(posedge hclk) disable iff (!hresetn)
		doze_en_ff && cpu_clk_en && doze_act_ff == 3'h3);
	c_fail_seen: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fail_ff));
endmodule : scsd_top

// ===== dv/scsd_osc_model.sv
// Oscillator and PLL stand-in on the far side of the clock selector
`timescale 1ns/1ps
module scsd_osc_model (
	input wire logic hclk, // Bench clock
	input wire logic start, // Requested oscillator powered
	input wire logic [7:0] delay, // Start-up cycles, slow or prompt
	output logic src_ready_async, // Oscillator started
	output logic new_clk_async, // Clock of the new source
	output logic pll_locked_async // PLL lock indication
);
	logic [7:0] cnt = 8'h00;
	logic [1:0] ph = 2'h0;
	// Start-up timer, restarted whenever power is removed
	always @(posedge hclk) begin
		if (!start) begin
			cnt <= 8'h00;
		end else if (cnt != delay) begin
			cnt <= cnt + 8'h01;
		end
	end
	assign src_ready_async = start && (cnt == delay);
	// Lock follows start-up; no lock while the PLL is off
	assign pll_locked_async = src_ready_async;
	// Clock stands still until the oscillator is up
	always @(posedge hclk) begin
		ph <= src_ready_async ? ph + 2'h1 : 2'h0;
	end
	assign new_clk_async = ph[1];
endmodule : scsd_osc_model

// ===== dv/scsd_tb.sv
// Self-checking bench for the clock select and divide block
`timescale 1ns/1ps
`include "scsd_regs.svh"
module testbench;
	localparam logic [11:0] ctl_ofs = `SCSD_OFS_OSC_CTRL;
	localparam logic [11:0] div_ofs = `SCSD_OFS_CLK_DIV;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, clk_fail_async, irq_async, osc_start;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, v;
	logic hreadyout, hresp, src_rdy, new_clk, pll_lk;
	logic [7:0] osc_delay;
	scsd_pkg::scsd_cfg_s cfg;
	scsd_pkg::scsd_src_e active_source;
	scsd_pkg::scsd_div_s div_out;
	logic [1:0] primary_submode;
	logic osc2_is_gpio, sec_osc_on, pin_select_locked, cpu_clk_en, periph_clk_en, rc_div_en;
	int num_errors = 0;
	int tests_run = 0;
	int c, p, f;
	int dv[8] = '{1, 2, 2, 8, 16, 32, 64, 256};
	always #50 hclk = ~hclk;
	scsd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cfg(cfg), .pll_locked_async(pll_lk), .src_ready_async(src_rdy),
		.new_clk_async(new_clk), .clk_fail_async(clk_fail_async), .irq_async(irq_async),
		.active_source(active_source), .primary_submode(primary_submode),
		.osc2_is_gpio(osc2_is_gpio), .sec_osc_on(sec_osc_on),
		.pin_select_locked(pin_select_locked), .div_out(div_out), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .rc_div_en(rc_div_en));
	scsd_osc_model osc_u (.hclk(hclk), .start(osc_start), .delay(osc_delay),
		.src_ready_async(src_rdy), .new_clk_async(new_clk), .pll_locked_async(pll_lk));
	// One single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		v = hrdata;
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask : chk
	task automatic rst(input logic [7:0] cv);
		cfg <= scsd_pkg::scsd_cfg_s'(cv);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		// Straps reach the registered outputs on the second edge; look after it
		repeat (3) @(posedge hclk);
	endtask : rst
	// Count clock enable pulses over a window
	task automatic cnt(input int n);
		c = 0;
		p = 0;
		f = 0;
		repeat (n) begin
			@(posedge hclk);
			c += (cpu_clk_en === 1'b1);
			p += (periph_clk_en === 1'b1);
			f += (rc_div_en === 1'b1);
		end
	endtask : cnt
	// Request a switch and wait for the request bit to drop
	task automatic sw(input logic [31:0] d, input logic [7:0] dl);
		osc_delay <= dl;
		bus(1'b1, ctl_ofs, d);
		osc_start <= 1'b1;
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h1, 32'h1);
		for (int n = 0; n < 100 && v[0] !== 1'b0; n++) bus(1'b0, ctl_ofs, 0);
	endtask : sw
	task automatic t_defaults;
		rst(8'hFF);
		bus(1'b0, ctl_ofs, 0);
		chk(v, 32'h7700);
		bus(1'b0, div_ofs, 0);
		chk(v, 32'h3040);
		bus(1'b0, 12'h010, 0);
		chk(v, 32'h0);
		chk(32'(hresp), 32'h0);
		bus(1'b1, ctl_ofs, 32'h0601);
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h7001, 32'h7000);
	endtask : t_defaults
	// Pin function strap set, crystal submode: only primary modes keep the pin
	task automatic t_modes;
		for (logic [3:0] i = 0; i < 8; i++) begin
			rst({i[2:0], 5'h0D});
			chk(32'(active_source), 32'(i));
			chk(32'(osc2_is_gpio), (i == 2 || i == 3) ? 32'h0 : 32'h1);
			bus(1'b0, ctl_ofs, 0);
			chk(v & 32'h7700, (32'(i) << 12) | (32'(i) << 8));
			chk(32'(primary_submode), (i == 2 || i == 3) ? 32'h1 : 32'h0);
		end
	endtask : t_modes
	task automatic t_switch;
		rst(8'hE9);
		sw(32'h0001, 8'h28);
		chk(v & 32'h7721, 32'h0020);
		chk(32'(active_source), 32'h0);
		osc_start <= 1'b0;
		sw(32'h0201, 8'h01);
		chk(v & 32'h7701, 32'h2200);
		chk(32'(primary_submode), 32'h1);
		osc_start <= 1'b0;
		bus(1'b1, ctl_ofs, 32'h0201);
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h7721, 32'h2200);
		bus(1'b1, ctl_ofs, 32'h0280);
		bus(1'b1, ctl_ofs, 32'h0081);
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h77C1, 32'h2280);
		// Monitor enabled: lock only freezes the requested field, switch aborts
		rst(8'hE8);
		bus(1'b1, ctl_ofs, 32'h0780);
		bus(1'b1, ctl_ofs, 32'h0081);
		@(posedge hclk);
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h7781, 32'h7780);
	endtask : t_switch
	task automatic t_flags;
		bus(1'b1, ctl_ofs, 32'h0200);
		clk_fail_async <= 1'b1;
		repeat (4) @(posedge hclk);
		clk_fail_async <= 1'b0;
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h8, 32'h8);
		bus(1'b1, ctl_ofs, 32'h0242);
		repeat (2) @(posedge hclk);
		chk(32'(sec_osc_on), 32'h1);
		chk(32'(pin_select_locked), 32'h1);
		bus(1'b0, ctl_ofs, 0);
		chk(v & 32'h885E, 32'h0042);
		bus(1'b1, ctl_ofs, 32'h0200);
		repeat (2) @(posedge hclk);
		chk({sec_osc_on, pin_select_locked}, 32'h0);
	endtask : t_flags
	task automatic t_div;
		bus(1'b1, div_ofs, 32'hFFFF);
		bus(1'b0, div_ofs, 0);
		chk(v, 32'hFFDF);
		chk(32'(div_out), 32'h1FFF);
		bus(1'b1, div_ofs, 32'h0080);
		bus(1'b0, div_ofs, 0);
		chk(v, 32'h00C0);
		for (int r = 1; r >= 0; r--) begin
			bus(1'b1, div_ofs, 32'(r << 15) | 32'h0800);
			irq_async <= 1'b1;
			repeat (6) @(posedge hclk);
			irq_async <= 1'b0;
			bus(1'b0, div_ofs, 0);
			chk(v, 32'(r << 15) | (r ? 32'h0 : 32'h0800));
		end
		// Old ratio of 128 may still run up to its wrap before the new one
		bus(1'b1, div_ofs, 32'h3840);
		cnt(300);
		cnt(256);
		chk(32'(c >= p / 8 - 1 && c <= p / 8 + 1), 32'h1);
		bus(1'b1, div_ofs, 32'h3040);
		cnt(64);
		cnt(256);
		chk(32'(c >= p - 1 && c <= p + 1), 32'h1);
		chk(32'(p), 32'h80);
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, div_ofs, 32'(k << 8) | 32'h0040);
			cnt(300);
			cnt(512);
			chk(32'(f >= 512 / dv[k] - 1 && f <= 512 / dv[k] + 1), 32'h1);
		end
	endtask : t_div
	task automatic tally_and_finish;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog against a hung handshake
	initial begin
		#5000000;
		num_errors++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cfg = scsd_pkg::scsd_cfg_s'(8'hFF);
		clk_fail_async = 1'b0;
		irq_async = 1'b0;
		osc_start = 1'b0;
		osc_delay = 8'h01;
		@(posedge hclk);
		t_defaults();
		t_modes();
		t_switch();
		t_flags();
		t_div();
		tally_and_finish();
	end
endmodule : testbench
